// file: rtl/segment_descriptor_type_checker.sv
// Segment descriptor type checker with AXI4-Lite register access
// Notes on behaviour
// - Class set: bit 11 picks data/code.
// - Data type bits: accessed, writable, expand-down.
// - Data clear write flag means read-only.
// - Stack load of unwritable data faults.
// - Expand-down: lower limit grows bottom.
// - Segment load sets accessed if writable memory.
// - Code type bits: accessed, readable, conforming.
// - Code data reads need read flag.
// - Protected mode never writes code segments.
// - Conforming transfer keeps current privilege.
// - Nonconforming other-level direct transfer faults.
// - Transfer to less privileged code faults.
// - Data nonconforming: deny less privileged; stack loads skip this check.
// - Class clear means system descriptor.
// - Decode 16-bit system and gate codes.
// - Decode 32-bit codes; four codes reserved.
// - Class flag: system clear, code/data set.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "segchk_defines.svh"

module segment_descriptor_type_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic GP_FAULT,
  output logic CHECK_DONE
);

  // ==========================================
  // Byte lane merge
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================
  // Register storage
  logic [31:0] desc_lo_r;
  logic [31:0] desc_hi_r;
  logic [31:0] ctrl_r;
  logic [31:0] offset_r;
  logic fault_r;
  logic limit_ok_r;
  logic acc_done_r;
  logic [1:0] new_cpl_r;
  segchk_pkg::desc_class_t class_r;
  segchk_pkg::sys_kind_t kind_r;

  // ==========================================
  // Bus slave state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_have_r;
  logic w_have_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic done_r;

  logic wr_fire;
  logic wr_mapped;
  logic go;
  logic [7:0] waddr8;
  logic [7:0] raddr8;
  logic [31:0] rdata_nxt;
  logic rd_mapped;

  assign waddr8 = 8'(waddr_r);
  assign raddr8 = 8'(ARADDR);
  // Write happens once both halves are held and the old response is gone
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_mapped = (waddr8 == `OFF_DESC_LO) || (waddr8 == `OFF_DESC_HI) || (waddr8 == `OFF_CTRL) ||
                     (waddr8 == `OFF_OFFSET) || (waddr8 == `OFF_GO) || (waddr8 == `OFF_STATUS);
  assign go = wr_fire && (waddr8 == `OFF_GO);

  // ==========================================
  // Decode and checks
  segchk_pkg::type_info_t info;
  segchk_pkg::limit_req_t lreq;
  segchk_pkg::op_t op;
  logic lim_ok;
  logic [1:0] cpl;
  logic [1:0] dpl;
  logic prot;
  logic is_wr;
  logic via_gate;
  logic mem_wr;
  logic fault_nxt;
  logic [1:0] new_cpl_nxt;
  logic acc_nxt;
  logic is_code;
  logic is_data;

  seg_type_decode u_decode (
    .desc_hi(desc_hi_r),
    .info(info)
  );

  assign lreq.limit = {desc_hi_r[`LIM_HI_MSB:`LIM_HI_LSB], desc_lo_r[`LIM_LO_MSB:`LIM_LO_LSB]};
  assign lreq.gran = desc_hi_r[`DESC_G_BIT];
  assign lreq.big = desc_hi_r[`DESC_B_BIT];
  assign lreq.expand_down = info.expand_down;
  assign lreq.offset = offset_r;

  seg_limit_check u_limit (
    .req(lreq),
    .ok(lim_ok)
  );

  assign op = segchk_pkg::op_t'(ctrl_r[`CTRL_OP_MSB:`CTRL_OP_LSB]);
  assign cpl = ctrl_r[`CTRL_CPL_MSB:`CTRL_CPL_LSB];
  assign dpl = desc_hi_r[`DPL_MSB:`DPL_LSB];
  assign prot = ctrl_r[`CTRL_PROT_BIT];
  assign is_wr = ctrl_r[`CTRL_WRITE_BIT];
  assign via_gate = ctrl_r[`CTRL_GATE_BIT];
  assign mem_wr = ctrl_r[`CTRL_MEMWR_BIT];
  assign is_code = info.cls == segchk_pkg::CLASS_CODE;
  assign is_data = info.cls == segchk_pkg::CLASS_DATA;

  // Outside protected operation no type or privilege check applies
  always_comb begin
    fault_nxt = 1'b0;
    new_cpl_nxt = cpl;
    if (prot) begin
      if (info.reserved) begin
        fault_nxt = 1'b1;
      end
      unique case (op)
        segchk_pkg::OP_LOAD_STACK: begin
          if (is_code || (is_data && !info.writable)) begin
            fault_nxt = 1'b1;
          end
        end
        segchk_pkg::OP_LOAD_DATA: begin
          if (is_code && !info.readable) begin
            fault_nxt = 1'b1;
          end
          if (is_data && (dpl < cpl)) begin
            fault_nxt = 1'b1;
          end
        end
        segchk_pkg::OP_TRANSFER: begin
          if (is_data) begin
            fault_nxt = 1'b1;
          end else if (is_code) begin
            if (dpl > cpl) begin
              fault_nxt = 1'b1;
            end else if (info.conforming) begin
              new_cpl_nxt = cpl;
            end else if ((dpl != cpl) && !via_gate) begin
              fault_nxt = 1'b1;
            end else begin
              new_cpl_nxt = dpl;
            end
          end
        end
        segchk_pkg::OP_ACCESS: begin
          if (is_code && is_wr) begin
            fault_nxt = 1'b1;
          end
          if (is_code && !is_wr && !info.readable) begin
            fault_nxt = 1'b1;
          end
          if (is_data && is_wr && !info.writable) begin
            fault_nxt = 1'b1;
          end
          if (is_data && ((dpl < cpl) || !lim_ok)) begin
            fault_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  // Read-only tables must be preset by software; no write attempted there
  assign acc_nxt = (op != segchk_pkg::OP_ACCESS) && (info.cls != segchk_pkg::CLASS_SYSTEM) &&
                   !fault_nxt && mem_wr;

  // ==========================================
  // Write address and data channels
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b0;
      waddr_r <= '0;
    end else if (AWVALID && awready_r) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b1;
      waddr_r <= AWADDR;
    end else begin
      if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      awready_r <= !aw_have_r && !bvalid_r && !(AWVALID && awready_r);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r <= `ZERO_WORD;
      wstrb_r <= '0;
    end else if (WVALID && wready_r) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r <= WDATA;
      wstrb_r <= WSTRB;
    end else begin
      if (wr_fire) begin
        w_have_r <= 1'b0;
      end
      wready_r <= !w_have_r && !bvalid_r;
    end
  end

  // ==========================================
  // Write response
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // Software registers
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      desc_lo_r <= `ZERO_WORD;
      desc_hi_r <= `ZERO_WORD;
      ctrl_r <= `CTRL_RESET;
      offset_r <= `ZERO_WORD;
    end else begin
      if (wr_fire && (waddr8 == `OFF_DESC_LO)) begin
        desc_lo_r <= merge_strb(desc_lo_r, wdata_r, wstrb_r);
      end
      if (wr_fire && (waddr8 == `OFF_DESC_HI)) begin
        desc_hi_r <= merge_strb(desc_hi_r, wdata_r, wstrb_r);
      end else if (go && acc_nxt) begin
        desc_hi_r[`TYPE_ACC_BIT] <= 1'b1;
      end
      if (wr_fire && (waddr8 == `OFF_CTRL)) begin
        ctrl_r <= merge_strb(ctrl_r, wdata_r, wstrb_r);
      end
      if (wr_fire && (waddr8 == `OFF_OFFSET)) begin
        offset_r <= merge_strb(offset_r, wdata_r, wstrb_r);
      end
    end
  end

  // ==========================================
  // Check results
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      fault_r <= 1'b0;
      limit_ok_r <= 1'b0;
      acc_done_r <= 1'b0;
      new_cpl_r <= '0;
      class_r <= segchk_pkg::CLASS_SYSTEM;
      kind_r <= segchk_pkg::SYS_NONE;
      done_r <= 1'b0;
    end else begin
      done_r <= go;
      if (go) begin
        fault_r <= fault_nxt;
        limit_ok_r <= lim_ok;
        acc_done_r <= acc_nxt;
        new_cpl_r <= new_cpl_nxt;
        class_r <= info.cls;
        kind_r <= info.kind;
      end
    end
  end

  // ==========================================
  // Read channel
  always_comb begin
    rd_mapped = 1'b1;
    unique case (raddr8)
      `OFF_DESC_LO: rdata_nxt = desc_lo_r;
      `OFF_DESC_HI: rdata_nxt = desc_hi_r;
      `OFF_CTRL: rdata_nxt = ctrl_r;
      `OFF_OFFSET: rdata_nxt = offset_r;
      `OFF_GO: rdata_nxt = `ZERO_WORD;
      `OFF_STATUS: rdata_nxt = {21'h00_0000, limit_ok_r, acc_done_r, new_cpl_r, kind_r, class_r, fault_r};
      default: begin
        rdata_nxt = `ZERO_WORD;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= `ZERO_WORD;
      rresp_r <= `RESP_OKAY;
    end else if (ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r) begin
      if (RREADY) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign GP_FAULT = fault_r;
  assign CHECK_DONE = done_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence write_held_s;
    aw_have_r && w_have_r && !bvalid_r;
  endsequence
  sequence answer_s;
    BVALID ##0 (BRESP == `RESP_OKAY || BRESP == `RESP_SLVERR);
  endsequence

  write_answer_a: assert property (write_held_s |=> answer_s)
    else $error("write response missing");
  stack_unwritable_a: assert property (go && prot && op == segchk_pkg::OP_LOAD_STACK && is_data &&
                                       !info.writable |=> GP_FAULT && CHECK_DONE)
    else $error("stack load of read-only data not faulted");
  code_write_a: assert property (go && prot && op == segchk_pkg::OP_ACCESS && is_code && is_wr
                                 |=> GP_FAULT)
    else $error("write to code segment allowed");
  class_code_a: assert property (go && desc_hi_r[`DESC_S_BIT] && desc_hi_r[`TYPE_MSB]
                                 |=> class_r == segchk_pkg::CLASS_CODE)
    else $error("code class not decoded");
  class_system_a: assert property (go && !desc_hi_r[`DESC_S_BIT]
                                   |=> class_r == segchk_pkg::CLASS_SYSTEM)
    else $error("system class not decoded");
  reserved_code_a: assert property (go && prot && !desc_hi_r[`DESC_S_BIT] &&
                                    desc_hi_r[`TYPE_MSB:`TYPE_LSB] == `SYS_RSVD13 |=> GP_FAULT)
    else $error("reserved system code not faulted");
  accessed_set_a: assert property (go && acc_nxt |=> desc_hi_r[`TYPE_ACC_BIT] [*2])
    else $error("accessed flag not set or not kept");
  conform_keep_a: assert property (go && prot && op == segchk_pkg::OP_TRANSFER && is_code &&
                                   info.conforming && dpl < cpl |=> !GP_FAULT && new_cpl_r == $past(cpl))
    else $error("conforming transfer changed privilege");
  nonconf_gate_a: assert property (go && prot && op == segchk_pkg::OP_TRANSFER && is_code &&
                                   !info.conforming && dpl < cpl && !via_gate |=> GP_FAULT)
    else $error("direct nonconforming transfer allowed");
  less_priv_a: assert property (go && prot && op == segchk_pkg::OP_TRANSFER && is_code && dpl > cpl
                                |=> GP_FAULT)
    else $error("transfer to less privileged code allowed");
  data_priv_a: assert property (go && prot && op == segchk_pkg::OP_LOAD_DATA && is_data && dpl < cpl
                                |=> GP_FAULT)
    else $error("less privileged data load allowed");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID ##1 (RVALID || $past(RREADY)))
    else $error("read answer malformed");

endmodule

// file: rtl/segchk_defines.svh
// Constant definitions for the segment descriptor type checker
`ifndef SEGCHK_DEFINES_SVH
`define SEGCHK_DEFINES_SVH

// ==========================================
// Register byte offsets
`define OFF_DESC_LO 8'h00
`define OFF_DESC_HI 8'h04
`define OFF_CTRL 8'h08
`define OFF_OFFSET 8'h0C
`define OFF_GO 8'h10
`define OFF_STATUS 8'h14

// ==========================================
// Reset values
`define CTRL_RESET 32'h0000_0010
`define ZERO_WORD 32'h0000_0000

// ==========================================
// Descriptor upper doubleword fields, plus the low limit field of the lower doubleword
`define TYPE_MSB 11
`define TYPE_LSB 8
`define TYPE_ACC_BIT 8
`define DESC_S_BIT 12
`define DPL_MSB 14
`define DPL_LSB 13
`define LIM_HI_MSB 19
`define LIM_HI_LSB 16
`define DESC_B_BIT 22
`define DESC_G_BIT 23
`define LIM_LO_MSB 15
`define LIM_LO_LSB 0

// ==========================================
// Limit scaling and upper bounds
`define GRAN_FILL 12'hFFF
`define GRAN_ZERO 12'h000
`define BOUND_BIG 32'hFFFF_FFFF
`define BOUND_SMALL 32'h0000_FFFF

// ==========================================
// Control register fields
`define CTRL_OP_MSB 1
`define CTRL_OP_LSB 0
`define CTRL_WRITE_BIT 2
`define CTRL_GATE_BIT 3
`define CTRL_PROT_BIT 4
`define CTRL_MEMWR_BIT 5
`define CTRL_CPL_MSB 7
`define CTRL_CPL_LSB 6

// ==========================================
// System type codes
`define SYS_RSVD0 4'h0
`define SYS_TSS16_AV 4'h1
`define SYS_LDT 4'h2
`define SYS_TSS16_BSY 4'h3
`define SYS_CALL16 4'h4
`define SYS_TASKG 4'h5
`define SYS_INT16 4'h6
`define SYS_TRAP16 4'h7
`define SYS_RSVD8 4'h8
`define SYS_TSS32_AV 4'h9
`define SYS_RSVD10 4'hA
`define SYS_TSS32_BSY 4'hB
`define SYS_CALL32 4'hC
`define SYS_RSVD13 4'hD
`define SYS_INT32 4'hE
`define SYS_TRAP32 4'hF

// ==========================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/segchk_pkg.sv
// Types shared by the segment descriptor type checker
package segchk_pkg;

  typedef enum logic [1:0] {CLASS_SYSTEM, CLASS_DATA, CLASS_CODE} desc_class_t;

  typedef enum logic [3:0] {
    SYS_NONE, SYS_RESERVED, SYS_TSS16_AVAIL, SYS_LOCAL_TABLE, SYS_TSS16_BUSY, SYS_CALL16,
    SYS_TASK_GATE, SYS_INT16, SYS_TRAP16, SYS_TSS32_AVAIL, SYS_TSS32_BUSY, SYS_CALL32,
    SYS_INT32, SYS_TRAP32
  } sys_kind_t;

  typedef enum logic [1:0] {OP_LOAD_STACK, OP_LOAD_DATA, OP_TRANSFER, OP_ACCESS} op_t;

  typedef struct packed {
    desc_class_t cls;
    logic accessed;
    logic writable;
    logic expand_down;
    logic readable;
    logic conforming;
    sys_kind_t kind;
    logic reserved;
  } type_info_t;

  typedef struct packed {
    logic [19:0] limit;
    logic gran;
    logic big;
    logic expand_down;
    logic [31:0] offset;
  } limit_req_t;

endpackage

// file: rtl/seg_type_decode.sv
// Descriptor class and type field decoder
`timescale 1ns/1ps
`include "segchk_defines.svh"

module seg_type_decode (
  input wire logic [31:0] desc_hi,
  output segchk_pkg::type_info_t info
);

  logic [3:0] typ;

  // Bit 20 is free for software and never looked at here
  always_comb begin
    typ = desc_hi[`TYPE_MSB:`TYPE_LSB];
    info = '0;
    info.kind = segchk_pkg::SYS_NONE;
    if (desc_hi[`DESC_S_BIT]) begin
      info.cls = typ[3] ? segchk_pkg::CLASS_CODE : segchk_pkg::CLASS_DATA;
      info.accessed = typ[0];
      if (typ[3]) begin
        info.readable = typ[1];
        info.conforming = typ[2];
      end else begin
        info.writable = typ[1];
        info.expand_down = typ[2];
      end
    end else begin
      info.cls = segchk_pkg::CLASS_SYSTEM;
      unique case (typ)
        `SYS_TSS16_AV: info.kind = segchk_pkg::SYS_TSS16_AVAIL;
        `SYS_LDT: info.kind = segchk_pkg::SYS_LOCAL_TABLE;
        `SYS_TSS16_BSY: info.kind = segchk_pkg::SYS_TSS16_BUSY;
        `SYS_CALL16: info.kind = segchk_pkg::SYS_CALL16;
        `SYS_TASKG: info.kind = segchk_pkg::SYS_TASK_GATE;
        `SYS_INT16: info.kind = segchk_pkg::SYS_INT16;
        `SYS_TRAP16: info.kind = segchk_pkg::SYS_TRAP16;
        `SYS_TSS32_AV: info.kind = segchk_pkg::SYS_TSS32_AVAIL;
        `SYS_TSS32_BSY: info.kind = segchk_pkg::SYS_TSS32_BUSY;
        `SYS_CALL32: info.kind = segchk_pkg::SYS_CALL32;
        `SYS_INT32: info.kind = segchk_pkg::SYS_INT32;
        `SYS_TRAP32: info.kind = segchk_pkg::SYS_TRAP32;
        `SYS_RSVD0, `SYS_RSVD8, `SYS_RSVD10, `SYS_RSVD13: begin
          info.kind = segchk_pkg::SYS_RESERVED;
          info.reserved = 1'b1;
        end
      endcase
    end
  end

endmodule

// file: rtl/seg_limit_check.sv
// Offset check against an expand-up or expand-down segment limit
`timescale 1ns/1ps
`include "segchk_defines.svh"

module seg_limit_check (
  input wire segchk_pkg::limit_req_t req,
  output logic ok
);

  logic [31:0] lim_eff;
  logic [31:0] upper;

  // Scaled limit leaves the low twelve offset bits unchecked
  always_comb begin
    lim_eff = req.gran ? {req.limit, `GRAN_FILL} : {`GRAN_ZERO, req.limit};
    upper = req.big ? `BOUND_BIG : `BOUND_SMALL;
    if (req.expand_down) begin
      // Lower limit means more room at the bottom
      ok = (req.offset > lim_eff) && (req.offset <= upper);
    end else begin
      ok = req.offset <= lim_eff;
    end
  end

endmodule

// file: verification/test_segment_descriptor_type_checker.sv
// Self-checking bench for the segment descriptor type checker
`timescale 1ns/1ps
`include "segchk_defines.svh"

module test_segment_descriptor_type_checker;
  // ==========================================
  // Table rows and bench signals
  typedef struct packed {
    logic s;
    logic [3:0] ty;
    logic [1:0] dpl;
    logic [1:0] op;
    logic wr;
    logic gate;
    logic [1:0] cpl;
    logic [31:0] off;
    logic flt;
    logic [1:0] cls;
  } row_t;

  localparam row_t ROWS [19] = '{
    '{1, 4'h2, 0, 0, 0, 0, 0, 32'h0000_0080, 0, 1}, '{1, 4'h0, 0, 0, 0, 0, 0, 32'h0000_0080, 1, 1},
    '{1, 4'h8, 0, 0, 0, 0, 0, 32'h0000_0080, 1, 2}, '{1, 4'h2, 0, 3, 1, 0, 0, 32'h0000_0080, 0, 1},
    '{1, 4'h0, 0, 3, 1, 0, 0, 32'h0000_0080, 1, 1}, '{1, 4'h6, 0, 3, 0, 0, 0, 32'h0000_0080, 1, 1},
    '{1, 4'h6, 0, 3, 0, 0, 0, 32'h0000_0200, 0, 1}, '{1, 4'h2, 0, 3, 0, 0, 0, 32'h0000_0200, 1, 1},
    '{1, 4'hA, 0, 3, 1, 0, 0, 32'h0000_0080, 1, 2}, '{1, 4'h8, 0, 3, 0, 0, 0, 32'h0000_0080, 1, 2},
    '{1, 4'hA, 0, 3, 0, 0, 0, 32'h0000_0080, 0, 2}, '{1, 4'hE, 0, 2, 0, 0, 3, 32'h0000_0000, 0, 2},
    '{1, 4'hA, 0, 2, 0, 0, 3, 32'h0000_0000, 1, 2}, '{1, 4'hA, 0, 2, 0, 1, 3, 32'h0000_0000, 0, 2},
    '{1, 4'hA, 3, 2, 0, 0, 3, 32'h0000_0000, 0, 2}, '{1, 4'hE, 3, 2, 0, 0, 0, 32'h0000_0000, 1, 2},
    '{1, 4'hA, 3, 2, 0, 0, 0, 32'h0000_0000, 1, 2}, '{1, 4'h2, 0, 1, 0, 0, 3, 32'h0000_0000, 1, 1},
    '{1, 4'h2, 3, 1, 0, 0, 0, 32'h0000_0000, 0, 1}
  };

  localparam segchk_pkg::sys_kind_t KINDS [16] = '{
    segchk_pkg::SYS_RESERVED, segchk_pkg::SYS_TSS16_AVAIL, segchk_pkg::SYS_LOCAL_TABLE, segchk_pkg::SYS_TSS16_BUSY,
    segchk_pkg::SYS_CALL16, segchk_pkg::SYS_TASK_GATE, segchk_pkg::SYS_INT16, segchk_pkg::SYS_TRAP16,
    segchk_pkg::SYS_RESERVED, segchk_pkg::SYS_TSS32_AVAIL, segchk_pkg::SYS_RESERVED, segchk_pkg::SYS_TSS32_BUSY,
    segchk_pkg::SYS_CALL32, segchk_pkg::SYS_RESERVED, segchk_pkg::SYS_INT32, segchk_pkg::SYS_TRAP32
  };

  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [3:0] WSTRB = 4'hF;
  logic [2:0] AWPROT = 3'h0;
  logic [2:0] ARPROT = 3'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, GP_FAULT, CHECK_DONE;
  logic [1:0] BRESP, RRESP, rsp;
  logic [31:0] RDATA, st, rd;
  logic done_seen;
  int fail_count = 0;
  int checks_done = 0;

  always #2 CLOCK = ~CLOCK;

  segment_descriptor_type_checker i_segment_descriptor_type_checker (
    .CLOCK(CLOCK), .NRST(NRST), .AWADDR(AWADDR), .AWPROT(AWPROT), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .GP_FAULT(GP_FAULT),
    .CHECK_DONE(CHECK_DONE)
  );

  // ==========================================
  // Helpers
  function automatic logic [31:0] dh(input logic s, input logic [3:0] ty, input logic [1:0] dpl);
    dh = {17'h0_0000, dpl, s, ty, 8'h00};
  endfunction

  // Protected operation and writable descriptor memory unless masked off
  function automatic logic [31:0] cr(input logic [1:0] op, input logic wr, input logic gate, input logic [1:0] cpl);
    cr = {24'h00_0000, cpl, 1'b1, 1'b1, gate, wr, op};
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped at its own handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    r = BRESP;
    done_seen = CHECK_DONE;
    BREADY <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
      if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic run_check(input logic [31:0] hi, input logic [31:0] ctl, input logic [31:0] off);
    axi_write(`OFF_DESC_HI, hi, rsp);
    axi_write(`OFF_CTRL, ctl, rsp);
    axi_write(`OFF_OFFSET, off, rsp);
    axi_write(`OFF_GO, 32'h0000_0000, rsp);
    cmp_word({31'h0, done_seen}, 32'h0000_0001);
    axi_read(`OFF_STATUS, st, rsp);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // Sequence
  initial begin
    #(4 * 20000);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge CLOCK);
    NRST <= 1'b1;
    cmp_word({30'h0, GP_FAULT, CHECK_DONE}, 32'h0000_0000);
    axi_read(`OFF_CTRL, rd, rsp);
    cmp_word(rd, `CTRL_RESET);
    axi_read(`OFF_STATUS, rd, rsp);
    cmp_word(rd, `ZERO_WORD);
    axi_read(8'h18, rd, rsp);
    cmp_word(rd, `ZERO_WORD);
    cmp_resp(rsp, `RESP_SLVERR);
    axi_write(8'h18, 32'hFFFF_FFFF, rsp);
    cmp_resp(rsp, `RESP_SLVERR);
    axi_read(`OFF_GO, rd, rsp);
    cmp_word(rd, `ZERO_WORD);
    // Limit 0x100, byte granular, small bound
    axi_write(`OFF_DESC_LO, 32'h0000_0100, rsp);
    cmp_resp(rsp, `RESP_OKAY);
    // Odd rows carry the software-available bit, which must change nothing
    for (int i = 0; i < 19; i++) begin
      run_check(dh(ROWS[i].s, ROWS[i].ty, ROWS[i].dpl) | (i[0] ? 32'h0010_0000 : 32'h0000_0000),
                cr(ROWS[i].op, ROWS[i].wr, ROWS[i].gate, ROWS[i].cpl), ROWS[i].off);
      cmp_word(st & 32'h0000_007F, {25'h0, segchk_pkg::SYS_NONE, ROWS[i].cls, ROWS[i].flt});
      cmp_word({31'h0, GP_FAULT}, {31'h0, ROWS[i].flt});
    end
    for (int c = 0; c < 16; c++) begin
      run_check(dh(1'b0, c[3:0], 2'd0), cr(2'd1, 1'b0, 1'b0, 2'd0), 32'h0000_0000);
      cmp_word(st & 32'h0000_007F, {25'h0, KINDS[c], 2'd0, KINDS[c] == segchk_pkg::SYS_RESERVED});
    end
    run_check(dh(1'b1, 4'hE, 2'd0), cr(2'd2, 1'b0, 1'b0, 2'd3), 32'h0000_0000);
    cmp_word({30'h0, st[8:7]}, 32'h0000_0003);
    run_check(dh(1'b1, 4'hA, 2'd0), cr(2'd2, 1'b0, 1'b1, 2'd3), 32'h0000_0000);
    cmp_word({30'h0, st[8:7]}, 32'h0000_0000);
    run_check(dh(1'b1, 4'h2, 2'd0), cr(2'd1, 1'b0, 1'b0, 2'd0), 32'h0000_0000);
    cmp_word({31'h0, st[9]}, 32'h0000_0001);
    axi_write(`OFF_CTRL, cr(2'd3, 1'b0, 1'b0, 2'd0), rsp);
    axi_write(`OFF_GO, 32'h0000_0000, rsp);
    axi_read(`OFF_DESC_HI, rd, rsp);
    cmp_word(rd, dh(1'b1, 4'h3, 2'd0));
    // Descriptor memory marked unwritable: flag must be left alone
    run_check(dh(1'b1, 4'h2, 2'd0), cr(2'd1, 1'b0, 1'b0, 2'd0) & 32'hFFFF_FFDF, 32'h0000_0000);
    axi_read(`OFF_DESC_HI, rd, rsp);
    cmp_word(rd, dh(1'b1, 4'h2, 2'd0));
    run_check(dh(1'b1, 4'h0, 2'd0), cr(2'd0, 1'b0, 1'b0, 2'd0) & 32'hFFFF_FFEF, 32'h0000_0000);
    cmp_word({31'h0, GP_FAULT}, 32'h0000_0000);
    // Table in read-only memory: accessed preset, check must not write it
    run_check(dh(1'b1, 4'h3, 2'd0), cr(2'd1, 1'b0, 1'b0, 2'd0) & 32'hFFFF_FFDF, 32'h0000_0000);
    axi_read(`OFF_DESC_HI, rd, rsp);
    cmp_word(rd, dh(1'b1, 4'h3, 2'd0));
    // Scaled limit and big upper bound on an expand-down segment
    run_check(dh(1'b1, 4'h6, 2'd0) | 32'h00C0_0000, cr(2'd3, 1'b0, 1'b0, 2'd0), 32'h0020_0000);
    cmp_word({30'h0, st[10], st[0]}, 32'h0000_0002);
    run_check(dh(1'b1, 4'h6, 2'd0) | 32'h00C0_0000, cr(2'd3, 1'b0, 1'b0, 2'd0), 32'h0010_0FFF);
    cmp_word({30'h0, st[10], st[0]}, 32'h0000_0001);
    @(posedge CLOCK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    axi_read(`OFF_CTRL, rd, rsp);
    cmp_word(rd, `CTRL_RESET);
    // Fault left standing by the last check must be gone after reset
    cmp_word({30'h0, GP_FAULT, CHECK_DONE}, 32'h0000_0000);
    axi_read(`OFF_STATUS, rd, rsp);
    cmp_word(rd, `ZERO_WORD);
    summarize();
  end
endmodule
